// ==== inc/hcf_regs.svh ====
// register offsets, field positions and reset values of the host mailbox
// assumes byte-wide registers on a 4-bit register index bus
`ifndef HCF_REGS_SVH
`define HCF_REGS_SVH

`define HCF_ADDR_IN_LEN      4'h0
`define HCF_ADDR_OUT_LEN     4'h1
`define HCF_ADDR_OUT_DATA    4'h2
`define HCF_ADDR_IN_DATA     4'h3
`define HCF_ADDR_IRQ_EN      4'h4
`define HCF_ADDR_STATUS      4'h5
`define HCF_ADDR_IRQ_CLR     4'h6
`define HCF_ADDR_OUT_REMAIN  4'h7
`define HCF_ADDR_IN_REMAIN   4'h8

`define HCF_BIT_IN_AVAIL     2
`define HCF_BIT_IN_OVF       1
`define HCF_BIT_OUT_MSG      0

`define HCF_RST_IRQ_EN       3'h0
`define HCF_RST_IN_AVAIL     1'b1
`define HCF_RST_ZERO8        8'h00
`define HCF_RST_LEN          5'h00
`define HCF_ONE_LEN          5'h01

`endif

// ==== inc/hcf_pkg.sv ====
// types shared by the host mailbox
// constants themselves live in hcf_regs.svh
package hcf_pkg;
    typedef struct packed {
        logic       inAvail;
        logic       inOvf;
        logic       outMsg;
    } hcf_flags_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } hcf_hostreq_t;
endpackage

// ==== core/hcf_mailbox.sv ====
// host command mailbox: two 16-byte byte FIFOs between a parallel host
// bus and the embedded controller, with length, status and irq registers.
// assumes host strobes are one-cycle pulses synchronous to clk, and that
// the controller side uses valid/ready style single-cycle strobes.
`timescale 1ns/1ps
`include "hcf_regs.svh"

// Summary of operation
// [R1] host writes message byte count 0..16 to input length after the bytes
// [R2] output length register shows byte length of the pending output message
// [R3] each output data read returns the next output message byte in order
// [R4] each input data write pushes one byte into the input FIFO; the code drops writes while full or locked
// [R5] host polls input-available before it starts writing a message
// [R6] irq enable holds bits 2..0, cleared at reset, upper bits reserved
// [R7] status bit 2 shows input FIFO can accept a message; resets to one
// [R8] status bit 1 shows input FIFO full (overflow); resets to zero
// [R9] status bit 0 shows an output message is waiting; resets to zero
// [R10] status bits 7..3 carry a read-only silicon revision code
// [R11] writing one to clear bit 1 clears overflow and input-available flags
// [R12] writing one to clear bit 0 clears output message flag; zero does nothing
// [R13] read-only count of output message bytes still unread by the host
// [R14] read-only count of input message bytes not yet consumed by controller
// [R15] host loads controller firmware through the input FIFO after reset
// [R16] both FIFOs are 16 bytes, reached only through mailbox registers
// [R17] host interrupt asserts while any enabled status flag is set
// [R18] input-available drops on length write until message fully consumed
// [R19] reserved bits read as zero and ignore writes
module hcf_mailbox #(
    parameter int         DEPTH    = 16,
    parameter logic [4:0] REV_CODE = 5'h0a  // arbitrary value
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // host register port
    input  wire hcf_pkg::hcf_hostreq_t hostReq,
    output logic [7:0]                 hostRdata,
    output logic                       hostIrq,
    // controller side: input message
    output logic                       ctlInMsgReady,
    output logic [4:0]                 ctlInMsgLen,
    output logic [7:0]                 ctlInData,
    input  wire logic                  ctlInPop,
    // controller side: output message
    input  wire logic                  ctlOutPush,
    input  wire logic [7:0]            ctlOutData,
    input  wire logic                  ctlOutCommit,
    output logic                       ctlOutFree
);
    localparam int AW = $clog2(DEPTH);

    // storage, memory owned here [R16]
    logic [7:0]    inMem  [DEPTH];
    logic [7:0]    outMem [DEPTH];
    logic [AW-1:0] inWp, inRp, outWp, outRp;
    logic [AW:0]   inCnt, outCnt;
    logic [4:0]    inLen, outLen, inRemain, outRemain;
    logic [2:0]    irqEn;
    hcf_pkg::hcf_flags_t flags;
    logic          inLocked;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    wire wrInData  = hostReq.wr && hit(hostReq.addr, `HCF_ADDR_IN_DATA);
    wire wrInLen   = hostReq.wr && hit(hostReq.addr, `HCF_ADDR_IN_LEN);
    wire wrIrqEn   = hostReq.wr && hit(hostReq.addr, `HCF_ADDR_IRQ_EN);
    wire wrIrqClr  = hostReq.wr && hit(hostReq.addr, `HCF_ADDR_IRQ_CLR);
    wire rdOutData = hostReq.rd && hit(hostReq.addr, `HCF_ADDR_OUT_DATA);

    wire inFull   = (inCnt == (AW+1)'(DEPTH));
    wire inEmpty  = (inCnt == '0);
    wire outFull  = (outCnt == (AW+1)'(DEPTH));
    wire outEmpty = (outCnt == '0);

    // bytes written while locked or full are dropped and flag overflow
    wire inPush  = wrInData && !inFull && !inLocked;                  // [R4]
    wire inOvfEv = wrInData && (inFull || inLocked);                  // [R8]
    wire inPop   = ctlInPop && inLocked && !inEmpty && inRemain != '0;
    wire outPop  = rdOutData && !outEmpty && flags.outMsg;            // [R3]
    wire outPush = ctlOutPush && !outFull && !flags.outMsg;
    // message done when controller drains the last byte
    wire inDone  = inPop && inRemain == `HCF_ONE_LEN;                  // [R18]
    wire outSet  = ctlOutCommit && !flags.outMsg;

    // set wins over clear on every flag
    wire next_inAvail = (inDone || (wrInLen && hostReq.wdata[4:0] == '0))
        ? 1'b1
        : (wrInLen ? 1'b0                                             // [R18]
        : ((wrIrqClr && hostReq.wdata[`HCF_BIT_IN_OVF]) ? 1'b0        // [R11]
        : flags.inAvail));
    wire next_inOvf  = inOvfEv || inFull ? 1'b1                        // [R8]
        : ((wrIrqClr && hostReq.wdata[`HCF_BIT_IN_OVF]) ? 1'b0        // [R11]
        : flags.inOvf);
    wire next_outMsg = outSet ? 1'b1                                   // [R9]
        : ((wrIrqClr && hostReq.wdata[`HCF_BIT_OUT_MSG]) ? 1'b0       // [R12]
        : flags.outMsg);

    wire [2:0] flagVec = {flags.inAvail, flags.inOvf, flags.outMsg};
    wire next_irq = |(flagVec & irqEn);                                // [R17]

    // read mux; reserved bits are zero
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = `HCF_RST_ZERO8;
        unique case (hostReq.addr)
            `HCF_ADDR_IN_LEN:     next_rdata = {3'h0, inLen};          // [R19]
            `HCF_ADDR_OUT_LEN:    next_rdata = {3'h0, outLen};         // [R2]
            // unwritten storage must not leak onto the bus before a message
            `HCF_ADDR_OUT_DATA:   next_rdata = flags.outMsg ? outMem[outRp]
                                             : `HCF_RST_ZERO8;         // [R3]
            `HCF_ADDR_IRQ_EN:     next_rdata = {5'h00, irqEn};         // [R6]
            `HCF_ADDR_STATUS:     next_rdata = {REV_CODE, flagVec};    // [R10]
            `HCF_ADDR_OUT_REMAIN: next_rdata = {3'h0, outRemain};      // [R13]
            `HCF_ADDR_IN_REMAIN:  next_rdata = {3'h0, inRemain};       // [R14]
            default:              next_rdata = `HCF_RST_ZERO8;
        endcase
    end

    // memories carry no reset; pointers guard against stale reads
    always_ff @(posedge clk) begin
        if (inPush)
            inMem[inWp] <= hostReq.wdata;                              // [R4]
        if (outPush)
            outMem[outWp] <= ctlOutData;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            inWp  <= '0;
            inRp  <= '0;
            inCnt <= '0;
        end else begin
            if (inPush)
                inWp <= inWp + 1'b1;
            if (inPop)
                inRp <= inRp + 1'b1;
            inCnt <= inCnt + (AW+1)'(inPush) - (AW+1)'(inPop);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            outWp  <= '0;
            outRp  <= '0;
            outCnt <= '0;
        end else begin
            if (outPush)
                outWp <= outWp + 1'b1;
            if (outPop)
                outRp <= outRp + 1'b1;
            outCnt <= outCnt + (AW+1)'(outPush) - (AW+1)'(outPop);
        end
    end

    // length write hands the message over; 16 is the top legal count
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            inLen    <= `HCF_RST_LEN;
            inRemain <= `HCF_RST_LEN;
            inLocked <= 1'b0;
        end else if (wrInLen && !inLocked) begin
            inLen    <= hostReq.wdata[4:0];                            // [R1]
            inRemain <= hostReq.wdata[4:0];                            // [R14]
            inLocked <= hostReq.wdata[4:0] != '0;
        end else if (inPop) begin
            inRemain <= inRemain - 1'b1;                               // [R14]
            inLocked <= !inDone;
        end
    end

    // output length latched from bytes staged when the message commits
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            outLen    <= `HCF_RST_LEN;
            outRemain <= `HCF_RST_LEN;
        end else if (outSet) begin
            outLen    <= 5'(outCnt);                                   // [R2]
            outRemain <= 5'(outCnt);                                   // [R13]
        end else if (outPop) begin
            outRemain <= outRemain - 1'b1;                             // [R13]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqEn <= `HCF_RST_IRQ_EN;                                  // [R6]
        end else if (wrIrqEn) begin
            irqEn <= hostReq.wdata[2:0];                               // [R19]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flags.inAvail <= `HCF_RST_IN_AVAIL;                        // [R7]
            flags.inOvf   <= 1'b0;
            flags.outMsg  <= 1'b0;
        end else begin
            flags.inAvail <= next_inAvail;                             // [R7]
            flags.inOvf   <= next_inOvf;
            flags.outMsg  <= next_outMsg;
        end
    end

    // registered outputs; read data is valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hostRdata     <= `HCF_RST_ZERO8;
            hostIrq       <= 1'b0;
            ctlInMsgReady <= 1'b0;
            ctlInMsgLen   <= `HCF_RST_LEN;
            ctlInData     <= `HCF_RST_ZERO8;
            ctlOutFree    <= 1'b0;
        end else begin
            hostRdata     <= next_rdata;
            hostIrq       <= next_irq;                                 // [R17]
            ctlInMsgReady <= inLocked && !inDone;
            ctlInMsgLen   <= inRemain;
            ctlInData     <= inMem[inRp + AW'(inPop)];
            ctlOutFree    <= !flags.outMsg && outEmpty;
        end
    end
endmodule // hcf_mailbox

// ==== verif/hcf_mailbox_monitor.sv ====
// checker for host mailbox register read-back, controller-side counts
// and irq masking; sees only the ports of hcf_mailbox
`timescale 1ns/1ps
module hcf_mailbox_monitor #(
    parameter logic [4:0] REV_CODE = 5'h0a
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst_b,
    // host side
    input wire hcf_pkg::hcf_hostreq_t hostReq,
    input wire logic [7:0]            hostRdata,
    input wire logic                  hostIrq,
    // controller side
    input wire logic                  ctlInMsgReady,
    input wire logic [4:0]            ctlInMsgLen,
    input wire logic                  ctlInPop
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [3:0] a = hostReq.addr;

    a_reset_quiet: assert property (
        $rose(rst_b) |-> hostRdata == 8'h00 && !hostIrq) else $error("busy");
    a_rev_code: assert property (
        a == 4'h5 |=> hostRdata[7:3] == REV_CODE) else $error("bad rev");
    a_rsvd_zero: assert property (
        a inside {4'h0, 4'h1, 4'h7, 4'h8} |=> hostRdata[7:5] == 3'h0)
        else $error("reserved bits set");
    a_unmapped_zero: assert property (
        a > 4'h8 |=> hostRdata == 8'h00) else $error("unmapped data");
    a_remain_mirror: assert property (
        a == 4'h8 && ctlInMsgReady |=> hostRdata == {3'h0, ctlInMsgLen})
        else $error("remain differs");
    a_pop_count: assert property (
        ctlInPop && ctlInMsgReady |-> ##2
        ctlInMsgLen == $past(ctlInMsgLen, 2) - 5'h01)
        else $error("pop count");
    a_locked_busy: assert property (
        a == 4'h5 && ctlInMsgReady |=> !hostRdata[2]) else $error("not locked");
    a_irq_mask: assert property (
        hostReq.wr && a == 4'h4 && hostReq.wdata[2:0] == 3'h0 |-> ##2 !hostIrq)
        else $error("masked irq high");

    c_len_write: cover property (hostReq.wr && a == 4'h0);
    c_pop: cover property (ctlInPop && ctlInMsgReady);
    c_irq: cover property (hostIrq);
endmodule // hcf_mailbox_monitor

bind hcf_mailbox hcf_mailbox_monitor #(.REV_CODE(REV_CODE)) i_hcf_mailbox_monitor (
    .clk, .rst_b, .hostReq, .hostRdata, .hostIrq, .ctlInMsgReady,
    .ctlInMsgLen, .ctlInPop);

// ==== verif/hcf_ctl_model.sv ====
// embedded controller model: drains input messages, publishes replies
// assumes mailbox samples its controller strobes on the rising edge
`timescale 1ns/1ps
module hcf_ctl_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // input message side
    input  wire logic       ctlInMsgReady,
    input  wire logic [7:0] ctlInData,
    input  wire logic       stall,
    output logic            ctlInPop,
    // output message side
    output logic            ctlOutPush,
    output logic [7:0]      ctlOutData,
    output logic            ctlOutCommit
);
    logic [7:0] got[$];
    // every other cycle at most, so the registered head byte has settled
    wire take = rst_b && ctlInMsgReady && !ctlInPop && !stall;
    initial begin
        ctlInPop     = 1'b0;
        ctlOutPush   = 1'b0;
        ctlOutData   = 8'h00;
        ctlOutCommit = 1'b0;
    end
    always @(negedge clk) begin
        if (take) got.push_back(ctlInData);
        ctlInPop <= take;
    end
    task automatic send(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            ctlOutPush = 1'b1;
            ctlOutData = base + i[7:0];
        end
        @(negedge clk);
        ctlOutPush   = 1'b0;
        ctlOutData   = ~ctlOutData;
        ctlOutCommit = 1'b1;
        @(negedge clk);
        ctlOutCommit = 1'b0;
    endtask
endmodule // hcf_ctl_model

// ==== verif/hcf_mailbox_test.sv ====
// self-checking bench of the host mailbox with a controller model
// assumes one clock; host strobes change on the falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module hcf_mailbox_test;
    localparam logic [4:0] REV = 5'h0b; // arbitrary value
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  stall = 1'b1;
    hcf_pkg::hcf_hostreq_t hostReq = '0;
    logic [7:0]            hostRdata, ctlInData, ctlOutData, v, d;
    logic [4:0]            ctlInMsgLen;
    logic                  hostIrq, ctlInMsgReady, ctlInPop, ctlOutFree;
    logic                  ctlOutPush, ctlOutCommit;
    logic [31:0]           seed = 32'hf791;
    logic [7:0]            sent[$];
    int                    n_errors = 0;
    int                    num_checks = 0;
    int                    n;

    hcf_mailbox #(.REV_CODE(REV)) i_hcf_mailbox (.clk, .rst_b, .hostReq,
        .hostRdata, .hostIrq, .ctlInMsgReady, .ctlInMsgLen, .ctlInData,
        .ctlInPop, .ctlOutPush, .ctlOutData, .ctlOutCommit, .ctlOutFree);
    hcf_ctl_model i_hcf_ctl_model (.clk, .rst_b, .ctlInMsgReady, .ctlInData,
        .stall, .ctlInPop, .ctlOutPush, .ctlOutData, .ctlOutCommit);

    initial forever #12.5 clk = ~clk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] stat(input logic [2:0] f);
        return {REV, f};
    endfunction
    task automatic req(input logic w, r, input logic [3:0] a, logic [7:0] x);
        @(negedge clk);
        hostReq = '{w, r, a, x};
    endtask
    // read data is registered, so it is taken one cycle after the request
    task automatic rd(input logic [3:0] a, input logic pop);
        req(1'b0, pop, a, 8'h00);
        req(1'b0, 1'b0, a, 8'h00);
        v = hostRdata;
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], 1'b0);
            if (a != 6) `CHK(v, a == 5 ? stat(3'b100) : 8'h00)
        end
        d = rnd() | 8'h04;
        req(1'b1, 1'b0, 4'h4, d);
        rd(4'h4, 1'b0);
        `CHK(v, {5'h00, d[2:0]})
        `CHK(hostIrq, 1'b1)
        req(1'b1, 1'b0, 4'h4, 8'h00);
        for (int k = 0; k < 3; k++) begin
            n = k == 0 ? 16 : k == 1 ? 1 : 17;
            stall = 1'b1;
            rd(4'h5, 1'b0);
            `CHK(v[2], 1'b1)
            sent.delete();
            i_hcf_ctl_model.got.delete();
            for (int i = 0; i < n; i++) begin
                sent.push_back(rnd());
                req(1'b1, 1'b0, 4'h3, sent[i]);
            end
            if (n == 17) begin
                req(1'b1, 1'b0, 4'h4, 8'h02);
                rd(4'h5, 1'b0);
                `CHK(v[1], 1'b1)
                `CHK(hostIrq, 1'b1)
                void'(sent.pop_back());
                n = 16;
            end
            req(1'b1, 1'b0, 4'h0, n[7:0]);
            rd(4'h8, 1'b0);
            `CHK(v, n[7:0])
            rd(4'h5, 1'b0);
            // overflow stays set from the first full message until cleared
            `CHK(v, stat(3'b010))
            stall = 1'b0;
            for (int t = 0; t < 100 && v[2] !== 1'b1; t++) rd(4'h5, 1'b0);
            `CHK(i_hcf_ctl_model.got == sent, 1'b1)
        end
        req(1'b1, 1'b0, 4'h6, 8'h02);
        rd(4'h5, 1'b0);
        `CHK(v[2:1], 2'b00)
        `CHK(hostIrq, 1'b0)
        n = 1 + rnd() % 16;
        d = rnd();
        i_hcf_ctl_model.send(n, d);
        rd(4'h1, 1'b0);
        `CHK(v, n[7:0])
        for (int i = 0; i < n; i++) begin
            rd(4'h7, 1'b0);
            `CHK(v, 8'(n - i))
            rd(4'h2, 1'b1);
            `CHK(v, 8'(d + i))
        end
        for (int i = 0; i < 2; i++) begin
            req(1'b1, 1'b0, 4'h6, i[7:0]);
            rd(4'h5, 1'b0);
            `CHK(v[0], i == 0)
        end
        report_and_stop();
    end
endmodule // hcf_mailbox_test
